// ---- pkg/sag_defines.svh ----
// Constants of the segmented address generator
`ifndef SAG_DEFINES_SVH
`define SAG_DEFINES_SVH
`define SAG_SEG_W 16
`define SAG_OFS_W 16
`define SAG_PHYS_W 20
`define SAG_SEG_SHIFT 4
`define SAG_DISP8_W 8
`define SAG_NUM_SEGS 4
`define SAG_SEG_RESET 16'h0000
`define SAG_CODE_RESET 16'hFFFF
`endif

// ---- pkg/sag_pkg.sv ----
// Types of the segmented address generator
`default_nettype none
package sag_pkg;
  // Segment base selector, index into the base file
  typedef enum logic [1:0] {
    SAG_SEG_EXTRA = 2'h0,
    SAG_SEG_CODE = 2'h1,
    SAG_SEG_STACK = 2'h2,
    SAG_SEG_DATA = 2'h3
  } sag_seg_t;
  // Reference type supplied by the execution unit
  typedef enum logic [2:0] {
    SAG_REF_FETCH = 3'h0,
    SAG_REF_IMM = 3'h1,
    SAG_REF_DATA = 3'h2,
    SAG_REF_STACK = 3'h3,
    SAG_REF_STR_DST = 3'h4
  } sag_ref_t;
  // Base register chosen for the effective offset
  typedef enum logic [1:0] {
    SAG_BASE_NONE = 2'h0,
    SAG_BASE_BX = 2'h1,
    SAG_BASE_BASE_PTR = 2'h2
  } sag_base_t;
endpackage : sag_pkg
`default_nettype wire

// ---- core/sag_seg_file.sv ----
// Four-entry segment base register file with registered read
`timescale 1ns/1ps
`default_nettype none
`include "sag_defines.svh"
module sag_seg_file (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [`SAG_SEG_W-1:0] wr_data,
  input wire logic [1:0] rd_sel,
  output logic [`SAG_SEG_W-1:0] rd_data_q,
  output logic [`SAG_SEG_W*`SAG_NUM_SEGS-1:0] all_q
);
  logic [`SAG_SEG_W-1:0] mem_q [`SAG_NUM_SEGS];

  // ----------------------------------------
  // Storage, one entry per segment
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SAG_NUM_SEGS; g++) begin : g_ent
      // Code base resets high so the first fetch lands near the top
      always_ff @(posedge clk) begin
        if (reset) begin
          mem_q[g] <= (g == 1) ? `SAG_CODE_RESET : `SAG_SEG_RESET;
        end else if (wr_en && wr_sel == 2'(g)) begin
          mem_q[g] <= wr_data;
        end
      end
      assign all_q[g*`SAG_SEG_W +: `SAG_SEG_W] = mem_q[g];
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_q <= `SAG_SEG_RESET;
    end else begin
      rd_data_q <= mem_q[rd_sel];
    end
  end
endmodule // sag_seg_file
`default_nettype wire

// ---- core/sag_top.sv ----
// Segmented physical address generator
// ----------------------------------------
// What this block does
// RL1 - Offsets are 16 bits, segment spans 64K
// RL2 - Physical address is base shifted 4 plus offset
// RL3 - Four 16-bit segment bases: code, data, stack, extra
// RL4 - Prefetch and immediate fetches use code base
// RL5 - Other data references use data base
// RL6 - Stack accesses and base-pointer references use stack
// RL7 - String destination via dest index uses extra
// RL8 - Override prefix replaces the implied segment
// RL9 - 32-bit pointer loads segment and offset together
// RL10 - Effective offset carry beyond 16 bits dropped
// RL11 - 8-bit displacement sign-extended to 16 bits
// RL12 - Physical address wraps within 1 Mbyte
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "sag_defines.svh"
module sag_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic REQ_VALID,
  input wire sag_pkg::sag_ref_t REQ_REF,
  input wire sag_pkg::sag_base_t REQ_BASE,
  input wire logic [`SAG_OFS_W-1:0] REQ_BASE_VAL,
  input wire logic REQ_IDX_EN,
  input wire logic [`SAG_OFS_W-1:0] REQ_IDX_VAL,
  input wire logic [`SAG_OFS_W-1:0] REQ_DISP,
  input wire logic REQ_DISP8,
  input wire logic REQ_OVR_EN,
  input wire sag_pkg::sag_seg_t REQ_OVR_SEG,
  input wire logic SEG_WR,
  input wire sag_pkg::sag_seg_t SEG_WR_SEL,
  input wire logic [`SAG_SEG_W-1:0] SEG_WR_DATA,
  input wire logic PTR_LOAD,
  input wire sag_pkg::sag_seg_t PTR_SEG,
  input wire logic [2*`SAG_SEG_W-1:0] PTR_DATA,
  output logic ADDR_VALID,
  output logic [`SAG_PHYS_W-1:0] PHYS_ADDR,
  output logic [`SAG_OFS_W-1:0] PTR_OFS,
  output logic PTR_OFS_VALID
);
  import sag_pkg::*;

  logic [`SAG_OFS_W-1:0] disp_ext;
  logic [`SAG_OFS_W-1:0] eff_ofs;
  sag_seg_t seg_sel;
  logic wr_en;
  logic [1:0] wr_sel;
  logic [`SAG_SEG_W-1:0] wr_data;
  logic [`SAG_SEG_W-1:0] base_rd_q;
  logic [`SAG_SEG_W*`SAG_NUM_SEGS-1:0] bases;
  logic [`SAG_OFS_W-1:0] ofs_q;
  logic valid_q;
  logic [`SAG_PHYS_W-1:0] sum;

  // ----------------------------------------
  // Effective offset
  // ----------------------------------------
  // Short displacement takes its sign from bit 7
  assign disp_ext = REQ_DISP8 ? {{(`SAG_OFS_W-`SAG_DISP8_W){REQ_DISP[`SAG_DISP8_W-1]}},
                    REQ_DISP[`SAG_DISP8_W-1:0]} : REQ_DISP; // [RL11]
  // Sum truncated to 16 bits so the offset wraps inside the segment
  always_comb begin
    eff_ofs = disp_ext;
    if (REQ_BASE != SAG_BASE_NONE) begin
      eff_ofs = 16'(eff_ofs + REQ_BASE_VAL); // [RL10] [RL1]
    end
    if (REQ_IDX_EN) begin
      eff_ofs = 16'(eff_ofs + REQ_IDX_VAL); // [RL10]
    end
  end

  // ----------------------------------------
  // Segment selection
  // ----------------------------------------
  // Override has priority over every implied choice
  always_comb begin
    unique case (REQ_REF)
      SAG_REF_FETCH, SAG_REF_IMM: seg_sel = SAG_SEG_CODE; // [RL4]
      SAG_REF_STACK: seg_sel = SAG_SEG_STACK; // [RL6]
      SAG_REF_STR_DST: seg_sel = SAG_SEG_EXTRA; // [RL7]
      default: seg_sel = (REQ_BASE == SAG_BASE_BASE_PTR) ? SAG_SEG_STACK
                                                   : SAG_SEG_DATA; // [RL6] [RL5]
    endcase
    if (REQ_OVR_EN) begin
      seg_sel = REQ_OVR_SEG; // [RL8]
    end
  end

  // ----------------------------------------
  // Segment base file
  // ----------------------------------------
  // A pointer load wins over a plain write in the same cycle
  assign wr_en = SEG_WR | PTR_LOAD;
  assign wr_sel = PTR_LOAD ? PTR_SEG : SEG_WR_SEL; // [RL9]
  assign wr_data = PTR_LOAD ? PTR_DATA[2*`SAG_SEG_W-1:`SAG_SEG_W] : SEG_WR_DATA; // [RL9]

  sag_seg_file u_seg (
    .clk(CLK),
    .reset(RESET),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .wr_data(wr_data),
    .rd_sel(seg_sel),
    .rd_data_q(base_rd_q), // [RL3]
    .all_q(bases)
  );

  // ----------------------------------------
  // Pipeline stage one: offset and valid
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ofs_q <= 16'h0000;
      valid_q <= 1'b0;
    end else begin
      ofs_q <= eff_ofs;
      valid_q <= REQ_VALID;
    end
  end

  // ----------------------------------------
  // Stage two: physical address
  // ----------------------------------------
  // Top carry dropped, address wraps in the 1 Mbyte space
  assign sum = 20'({base_rd_q, 4'h0} + {4'h0, ofs_q}); // [RL2] [RL12]
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PHYS_ADDR <= 20'h00000;
      ADDR_VALID <= 1'b0;
    end else begin
      PHYS_ADDR <= sum;
      ADDR_VALID <= valid_q;
    end
  end

  // Offset half of a loaded pointer, handed back to the execution unit
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PTR_OFS <= 16'h0000;
      PTR_OFS_VALID <= 1'b0;
    end else begin
      PTR_OFS <= PTR_LOAD ? PTR_DATA[`SAG_SEG_W-1:0] : PTR_OFS; // [RL9]
      PTR_OFS_VALID <= PTR_LOAD;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_PHYS_SUM: assert property (@(posedge CLK) disable iff (RESET) // [RL2]
    valid_q |=> PHYS_ADDR == 20'({$past(base_rd_q), 4'h0} + {4'h0, $past(ofs_q)}))
    else $error("physical address not base*16+offset");
  AST_LATENCY: assert property (@(posedge CLK) disable iff (RESET) // [RL3]
    REQ_VALID |-> ##2 ADDR_VALID)
    else $error("address valid not two cycles after request");
  AST_FETCH_CODE: assert property (@(posedge CLK) disable iff (RESET) // [RL4]
    (REQ_REF == SAG_REF_FETCH && !REQ_OVR_EN) |-> seg_sel == SAG_SEG_CODE)
    else $error("fetch not on code base");
  AST_DATA_DEF: assert property (@(posedge CLK) disable iff (RESET) // [RL5]
    (REQ_REF == SAG_REF_DATA && REQ_BASE != SAG_BASE_BASE_PTR && !REQ_OVR_EN)
    |-> seg_sel == SAG_SEG_DATA)
    else $error("data reference not on data base");
  AST_BASEPTR_STACK: assert property (@(posedge CLK) disable iff (RESET) // [RL6]
    (REQ_REF == SAG_REF_DATA && REQ_BASE == SAG_BASE_BASE_PTR && !REQ_OVR_EN)
    |-> seg_sel == SAG_SEG_STACK)
    else $error("base-pointer reference not on stack base");
  AST_STR_EXTRA: assert property (@(posedge CLK) disable iff (RESET) // [RL7]
    (REQ_REF == SAG_REF_STR_DST && !REQ_OVR_EN) |-> seg_sel == SAG_SEG_EXTRA)
    else $error("string destination not on extra base");
  AST_OVERRIDE: assert property (@(posedge CLK) disable iff (RESET) // [RL8]
    REQ_OVR_EN |-> ##1 base_rd_q == $past(bases[16*REQ_OVR_SEG +: 16]))
    else $error("override segment not used");
  AST_PTR_LOAD: assert property (@(posedge CLK) disable iff (RESET) // [RL9]
    PTR_LOAD |=> PTR_OFS_VALID && PTR_OFS == $past(PTR_DATA[15:0])
    && bases[16*$past(PTR_SEG) +: 16] == $past(PTR_DATA[31:16]))
    else $error("pointer load did not replace segment and offset");
  AST_DISP8: assert property (@(posedge CLK) disable iff (RESET) // [RL11]
    (REQ_DISP8 && REQ_BASE == SAG_BASE_NONE && !REQ_IDX_EN)
    |-> eff_ofs[15:8] == {8{REQ_DISP[7]}})
    else $error("short displacement not sign-extended");
endmodule // sag_top
`default_nettype wire

// ---- dv/sag_bus_sink.sv ----
// Bus-side consumer model that latches each generated address
`timescale 1ns/1ps
`default_nettype none
module sag_bus_sink (
  input wire logic clk,
  input wire logic addr_valid,
  input wire logic [19:0] phys_addr,
  output logic [19:0] last_q
);
  // Latch on the valid pulse only, since the address bus moves every cycle
  always_ff @(posedge clk) begin
    if (addr_valid) begin
      last_q <= phys_addr;
    end
  end
endmodule // sag_bus_sink
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the segmented address generator
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sag_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic rv = 0;
  logic ie = 0;
  logic d8 = 0;
  logic oe = 0;
  logic sw = 0;
  logic pl = 0;
  sag_ref_t rf = SAG_REF_DATA;
  sag_base_t bs = SAG_BASE_NONE;
  sag_seg_t os = SAG_SEG_DATA;
  sag_seg_t wsel = SAG_SEG_DATA;
  sag_seg_t psel = SAG_SEG_DATA;
  logic [15:0] bv = 0;
  logic [15:0] iv = 0;
  logic [15:0] ds = 0;
  logic [15:0] wd = 0;
  logic [31:0] pd = 0;
  logic av;
  logic pov;
  logic [19:0] pa;
  logic [19:0] last;
  logic [15:0] po;
  int errors = 0;
  int n_tests = 0;
  sag_top i_sag_top (.CLK(clk), .RESET(rst), .REQ_VALID(rv), .REQ_REF(rf), .REQ_BASE(bs),
    .REQ_BASE_VAL(bv), .REQ_IDX_EN(ie), .REQ_IDX_VAL(iv), .REQ_DISP(ds), .REQ_DISP8(d8),
    .REQ_OVR_EN(oe), .REQ_OVR_SEG(os), .SEG_WR(sw), .SEG_WR_SEL(wsel), .SEG_WR_DATA(wd),
    .PTR_LOAD(pl), .PTR_SEG(psel), .PTR_DATA(pd), .ADDR_VALID(av), .PHYS_ADDR(pa),
    .PTR_OFS(po), .PTR_OFS_VALID(pov));
  sag_bus_sink i_sag_bus_sink (.clk(clk), .addr_valid(av), .phys_addr(pa), .last_q(last));
  // ----------------------------------------
  // Shared drivers and comparison
  // ----------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(string nm, logic [19:0] exp, logic [19:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One request cycle, then the answer two edges later as a single pulse
  task automatic req(sag_ref_t r, sag_base_t b, logic [15:0] v, logic [15:0] x,
      logic [15:0] d, logic e8, logic ov, sag_seg_t s, logic [19:0] exp);
    rf = r;
    bs = b;
    bv = v;
    ie = (x != 16'h0000);
    iv = x;
    ds = d;
    d8 = e8;
    oe = ov;
    os = s;
    rv = 1;
    @(posedge clk) #1 rv = 0;
    chk("early valid", 20'h00000, {19'h00000, av});
    @(posedge clk) #1 chk("valid", 20'h00001, {19'h00000, av});
    chk("address", exp, pa);
    @(posedge clk) #1 chk("sink", exp, last);
    chk("valid end", 20'h00000, {19'h00000, av});
  endtask
  // An idle edge after each write keeps the strobe from toggling twice in one step
  task automatic wseg(sag_seg_t s, logic [15:0] d);
    wsel = s;
    wd = d;
    sw = 1;
    @(posedge clk) #1 sw = 0;
    @(posedge clk) #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("reset valid", 20'h00000, {19'h00000, av});
    req(SAG_REF_FETCH, SAG_BASE_NONE, 0, 0, 16'h0020, 0, 0, SAG_SEG_DATA, 20'h00010);
  endtask
  task automatic t_select;
    wseg(SAG_SEG_DATA, 16'h1234);
    wseg(SAG_SEG_STACK, 16'h2000);
    wseg(SAG_SEG_EXTRA, 16'h3000);
    req(SAG_REF_DATA, SAG_BASE_NONE, 0, 0, 16'h0005, 0, 0, SAG_SEG_CODE, 20'h12345);
    req(SAG_REF_STACK, SAG_BASE_NONE, 0, 0, 16'h0005, 0, 0, SAG_SEG_DATA, 20'h20005);
    req(SAG_REF_DATA, SAG_BASE_BASE_PTR, 16'h0010, 0, 0, 0, 0, SAG_SEG_DATA, 20'h20010);
    req(SAG_REF_STR_DST, SAG_BASE_NONE, 0, 16'h0008, 0, 0, 0, SAG_SEG_DATA, 20'h30008);
    req(SAG_REF_IMM, SAG_BASE_NONE, 0, 0, 16'h0005, 0, 0, SAG_SEG_DATA, 20'hFFFF5);
  endtask
  // Each override code must beat the implied code base of a fetch
  task automatic t_override;
    logic [19:0] tbl [4];
    tbl = '{20'h30000, 20'hFFFF0, 20'h20000, 20'h12340};
    for (int i = 0; i < 4; i++) begin
      req(SAG_REF_FETCH, SAG_BASE_NONE, 0, 0, 0, 0, 1, sag_seg_t'(i), tbl[i]);
    end
  endtask
  task automatic t_offset;
    req(SAG_REF_DATA, SAG_BASE_BX, 16'hFFFF, 16'h0002, 16'h12F0, 1, 0, SAG_SEG_DATA,
      20'h22331);
    req(SAG_REF_DATA, SAG_BASE_NONE, 0, 0, 16'hFF34, 1, 0, SAG_SEG_DATA, 20'h12374);
  endtask
  task automatic t_ptr;
    psel = SAG_SEG_DATA;
    pd = 32'h4000ABCD;
    pl = 1;
    @(posedge clk) #1 pl = 0;
    chk("ptr valid", 20'h00001, {19'h00000, pov});
    chk("ptr offset", 20'h0ABCD, {4'h0, po});
    req(SAG_REF_DATA, SAG_BASE_NONE, 0, 0, 16'h0001, 0, 0, SAG_SEG_DATA, 20'h40001);
    chk("ptr valid end", 20'h00000, {19'h00000, pov});
    chk("ptr offset held", 20'h0ABCD, {4'h0, po});
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    t_reset();
    t_select();
    t_override();
    t_offset();
    t_ptr();
    finish_test();
  end
  // About 50 cycles of work; stop long after that
  initial begin
    #40000;
    errors++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
